// ### hdl/wiper_ctl_defines.svh
`ifndef WIPER_CTL_DEFINES_SVH
`define WIPER_CTL_DEFINES_SVH

// Clock rate and timing figures
`define CLK_HZ             250_000_000
`define DEBOUNCE_US        1_000
`define STEP_HOLD_MS       1_000
`define REPEAT_MS          100
`define IDLE_REVERSE_MS    1_000
`define NV_DELAY_MS        2_000
`define MODE_DECIDE_US     10
`define CYC_PER_US         (`CLK_HZ / 1_000_000)
`define CYC_PER_MS         (`CLK_HZ / 1_000)
`define DEBOUNCE_CYC       (`DEBOUNCE_US * `CYC_PER_US)
`define HOLD_CYC           (`STEP_HOLD_MS * `CYC_PER_MS)
`define REPEAT_CYC         (`REPEAT_MS * `CYC_PER_MS)
`define IDLE_REV_CYC       (`IDLE_REVERSE_MS * `CYC_PER_MS)
`define NV_DELAY_CYC       (`NV_DELAY_MS * `CYC_PER_MS)
`define MODE_DECIDE_CYC    (`MODE_DECIDE_US * `CYC_PER_US)

// Wiper layout
`define TAP_COUNT          64
`define WIPER_W            6
`define WIPER_MAX          6'h3F
`define STORE_BIT          3

`endif

// ### hdl/wiper_ctl_pkg.sv
package wiper_ctl_pkg;

  typedef enum logic [1:0]
  {
    MODE_WAIT   = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_DUAL   = 2'b10
  } mode_t;

  typedef enum logic [1:0]
  {
    NV_IDLE  = 2'b00,
    NV_ARMED = 2'b01,
    NV_WRITE = 2'b10
  } nv_state_t;

  // Debounced step requests, one per input
  typedef struct packed
  {
    logic up_contact;
    logic down_contact;
    logic digital;
  } step_req_t;

  // Nonvolatile store request
  typedef struct packed
  {
    logic       valid;
    logic [5:0] data;
  } nv_write_t;

endpackage

// ### hdl/wiper_ctl.sv
`timescale 1ns/10ps
`include "wiper_ctl_defines.svh"

// Functional notes
// R01: Wiper holds one of 64 evenly spaced tap positions.
// R02: Step inputs are active low; falling edge starts a pulse.
// R03: Each recognised pulse moves the wiper exactly one tap.
// R04: Driver holds single pulse low over 1 ms and at most 1 s.
// R05: Pulses need 1 ms high between them, otherwise they merge.
// R06: Held input steps once more every 100 ms after 1 s.
// R07: Single-button mode: up contact moves both ways, down contact unused.
// R08: Single-button mode only when down contact is high at power-up.
// R09: Single-button first direction is opposite to previous activity.
// R10: Single-button reverses after 1 s idle or at a range end.
// R11: Digital input acts like single button, faster, in every mode.
// R12: Floating down contact at power-up selects dual-button mode.
// R13: Dual mode: up contact steps up, down contact steps down, no wait.
// R14: Dual mode stays at range end until opposite request.
// R15: Up and down contacts are debounced internally.
// R16: Power-up restores wiper from nonvolatile memory.
// R17: First change after power-up is stored 2 s after change.
// R18: Later stores only when change reaches the fourth bit.
// R19: User keeps position and power 2 s after change for storage.
// R20: After wear-out, keep working; restore last good value at power-up.
// R21: Button mode decided within 10 us after reset release.
// R22: Wiper is a six-bit counter saturating at 0 and 63.
module wiper_ctl
#(
  parameter int DEBOUNCE_CYC    = `DEBOUNCE_CYC,
  parameter int DIGITAL_CYC     = 250,
  parameter int HOLD_CYC        = `HOLD_CYC,
  parameter int REPEAT_CYC      = `REPEAT_CYC,
  parameter int IDLE_REV_CYC    = `IDLE_REV_CYC,
  parameter int NV_DELAY_CYC    = `NV_DELAY_CYC,
  parameter int MODE_DECIDE_CYC = `MODE_DECIDE_CYC
)
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  input  wire logic                   up_contact_input_b,
  input  wire logic                   down_contact_input_b,
  input  wire logic                   digital_input_b,
  input  wire logic [5:0]             nv_stored_pos,
  input  wire logic                   nv_worn_out,
  output logic [5:0]                  wiper_pos,
  output wiper_ctl_pkg::nv_write_t    nv_write,
  output logic                        single_mode,
  output logic                        mode_valid
);

  localparam int CW = 32;

  initial
  begin
    if (DEBOUNCE_CYC < 1 || DIGITAL_CYC < 1 || HOLD_CYC <= DEBOUNCE_CYC ||
        REPEAT_CYC < 1 || IDLE_REV_CYC < 1 || NV_DELAY_CYC < 1 ||
        MODE_DECIDE_CYC < 3)
      $error("wiper_ctl: illegal timing parameters");
  end

  function automatic logic [5:0] sat_step(input logic [5:0] p, input logic up);
    if (up)
      sat_step = (p == `WIPER_MAX) ? p : p + 6'h01;
    else
      sat_step = (p == 6'h00) ? p : p - 6'h01;
  endfunction

  // Reset release through two flops
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Pin synchronisers; inverted so one means asserted
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end
    else
    begin
      pin_s1_q <= ~{up_contact_input_b, down_contact_input_b, digital_input_b}; // see R02
      pin_s2_q <= pin_s1_q;
    end
  end

  // Per-input pulse decoder: filter, initial step, hold, repeat
  logic [2:0] step_pulse;
  logic [2:0] active_lvl;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_in
      // Contacts get the long filter; digital input the short one
      localparam int FILT = (gi == 0) ? DIGITAL_CYC : DEBOUNCE_CYC;
      logic [CW-1:0] filt_q;
      logic          lvl_q;
      logic [CW-1:0] hold_q;
      wire           raw = pin_s2_q[gi];
      wire           flip = (raw != lvl_q) && (filt_q >= FILT - 1);
      wire           rep  = lvl_q && (hold_q == HOLD_CYC + REPEAT_CYC - 1);
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          filt_q <= '0;
          lvl_q  <= 1'b0;
          hold_q <= '0;
        end
        else
        begin
          // Level must be stable for the filter time to flip: see R15 see R05
          filt_q <= (raw == lvl_q || flip) ? '0 : filt_q + 1;
          lvl_q  <= flip ? raw : lvl_q;
          if (flip || !lvl_q)
            hold_q <= '0;
          else if (rep)
            hold_q <= CW'(HOLD_CYC); // see R06
          else
            hold_q <= hold_q + 1;
        end
      end
      // One step on accepted press, then every repeat period once held past the hold time: see R03 see R06
      assign step_pulse[gi] = (flip && raw) || rep;
      assign active_lvl[gi] = lvl_q;
    end
  endgenerate

  wire step_uc = step_pulse[2];
  wire step_dc = step_pulse[1];
  wire step_d  = step_pulse[0];

  // Mode strap caught after reset release
  wiper_ctl_pkg::mode_t mode_q;
  logic [CW-1:0]        mode_cnt_q;
  wire                  mode_done = (mode_cnt_q == MODE_DECIDE_CYC - 1);
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q     <= wiper_ctl_pkg::MODE_WAIT;
      mode_cnt_q <= '0;
    end
    else if (mode_q == wiper_ctl_pkg::MODE_WAIT)
    begin
      mode_cnt_q <= mode_cnt_q + 1;
      // High (not asserted) down contact means tied to supply: see R08 see R12 see R21
      if (mode_done)
        mode_q <= pin_s2_q[1] ? wiper_ctl_pkg::MODE_DUAL : wiper_ctl_pkg::MODE_SINGLE;
    end
  end

  wire is_single = (mode_q == wiper_ctl_pkg::MODE_SINGLE);
  wire is_dual   = (mode_q == wiper_ctl_pkg::MODE_DUAL);

  // Single-button direction; one means up
  logic          dir_q;
  logic          last_dir_q;
  logic          fresh_q;
  logic [CW-1:0] idle_q;
  logic [5:0]    pos_q;
  logic          loaded_q;

  wire single_act = step_uc && is_single;            // see R07
  wire shared_act = single_act || step_d;            // see R11
  wire any_active = (active_lvl[2] && is_single) || active_lvl[0];
  wire idle_hit   = (idle_q == IDLE_REV_CYC - 1);
  // Start of activity after idle runs opposite to last movement: see R09
  wire use_dir    = fresh_q ? !last_dir_q : dir_q;
  wire at_end     = use_dir ? (pos_q == `WIPER_MAX) : (pos_q == 6'h00);
  wire move_dir   = at_end ? !use_dir : use_dir;     // see R10

  wire       dual_up   = step_uc && is_dual;         // see R13
  wire       dual_down = step_dc && is_dual;         // see R13
  wire       do_move   = loaded_q && (shared_act || dual_up || dual_down);
  wire       dir_now   = shared_act ? move_dir : dual_up;
  // Dual mode just saturates at ends: see R14 see R22
  wire [5:0] pos_next  = sat_step(pos_q, dir_now);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dir_q      <= 1'b1;
      last_dir_q <= 1'b0;
      fresh_q    <= 1'b1;
      idle_q     <= '0;
    end
    else
    begin
      if (shared_act)
      begin
        dir_q      <= move_dir;
        last_dir_q <= move_dir;
        fresh_q    <= 1'b0;
      end
      else if (dual_up || dual_down)
        last_dir_q <= dual_up;
      // Idle over 1 s reverses next movement: see R10
      if (any_active)
        idle_q <= '0;
      else if (idle_hit)
      begin
        idle_q  <= '0;
        fresh_q <= 1'b1;
      end
      else if (!fresh_q)
        idle_q <= idle_q + 1;
    end
  end

  // Wiper position register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_q    <= 6'h00;
      loaded_q <= 1'b0;
    end
    else if (!loaded_q)
    begin
      pos_q    <= nv_stored_pos; // see R16 see R20
      loaded_q <= 1'b1;
    end
    else if (do_move)
      pos_q <= pos_next; // see R01 see R03 see R22
  end

  // Nonvolatile update scheduling
  wiper_ctl_pkg::nv_state_t nv_q;
  logic [CW-1:0]            nv_cnt_q;
  logic [5:0]               saved_q;
  logic                     first_done_q;
  logic [5:0]               nv_data_q;
  logic                     nv_valid_q;

  wire [5:0] diff     = (pos_q > saved_q) ? pos_q - saved_q : saved_q - pos_q;
  // Store once the move reaches the fourth bit: see R18
  wire       big_move = (diff[5:`STORE_BIT] != '0);
  wire       want     = loaded_q && (pos_q != saved_q) && (!first_done_q || big_move);
  wire       nv_hit   = (nv_cnt_q == NV_DELAY_CYC - 1);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nv_q         <= wiper_ctl_pkg::NV_IDLE;
      nv_cnt_q     <= '0;
      saved_q      <= 6'h00;
      first_done_q <= 1'b0;
      nv_data_q    <= 6'h00;
      nv_valid_q   <= 1'b0;
    end
    else
    begin
      nv_valid_q <= 1'b0;
      if (!loaded_q)
        saved_q <= nv_stored_pos;
      unique case (nv_q)
        wiper_ctl_pkg::NV_IDLE:
        begin
          nv_cnt_q <= '0;
          if (want)
            nv_q <= wiper_ctl_pkg::NV_ARMED;
        end
        wiper_ctl_pkg::NV_ARMED:
        begin
          // Every further move restarts the 2 s wait: see R17 see R19
          if (do_move || !want)
            nv_cnt_q <= '0;
          else
            nv_cnt_q <= nv_cnt_q + 1;
          if (!want)
            nv_q <= wiper_ctl_pkg::NV_IDLE;
          else if (nv_hit && !do_move)
            nv_q <= wiper_ctl_pkg::NV_WRITE;
        end
        wiper_ctl_pkg::NV_WRITE:
        begin
          // Worn memory ignores the write; live operation continues: see R20
          nv_valid_q   <= !nv_worn_out;
          nv_data_q    <= pos_q;
          saved_q      <= pos_q;
          first_done_q <= 1'b1; // see R17
          nv_q         <= wiper_ctl_pkg::NV_IDLE;
        end
      endcase
    end
  end

  assign wiper_pos      = pos_q;
  assign nv_write.valid = nv_valid_q;
  assign nv_write.data  = nv_data_q;
  assign single_mode    = is_single;
  assign mode_valid     = (mode_q != wiper_ctl_pkg::MODE_WAIT);

endmodule

// ### test/wiper_ctl_chk.sv
`timescale 1ns/10ps
module wiper_ctl_chk
#(
  parameter int NV_DELAY_CYC = 40
)
(
  input wire logic                     sys_clk,
  input wire logic                     rst_b,
  input wire logic                     up_contact_input_b,
  input wire logic                     down_contact_input_b,
  input wire logic                     digital_input_b,
  input wire logic [5:0]               nv_stored_pos,
  input wire logic                     nv_worn_out,
  input wire logic [5:0]               wiper_pos,
  input wire wiper_ctl_pkg::nv_write_t nv_write,
  input wire logic                     single_mode,
  input wire logic                     mode_valid
);
  logic [7:0] quiet_q;
  logic [7:0] dn_q;
  logic [7:0] still_q;
  logic [7:0] up_q;
  logic [5:0] last_q;

  // Saturate so long idle spans never wrap back to small counts
  function automatic logic [7:0] sat(input logic [7:0] x);
    return x + {7'h00, ~&x};
  endfunction

  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      quiet_q <= 8'h00;
      dn_q    <= 8'h00;
      still_q <= 8'h00;
      up_q    <= 8'h00;
      last_q  <= 6'h00;
    end
    else
    begin
      quiet_q <= (up_contact_input_b & digital_input_b) ? sat(quiet_q) : 8'h00;
      dn_q    <= down_contact_input_b ? sat(dn_q) : 8'h00;
      still_q <= (wiper_pos == last_q) ? sat(still_q) : 8'h00;
      up_q    <= sat(up_q);
      last_q  <= wiper_pos;
    end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  AST_ONE_TAP: assert property (
    mode_valid && $past(mode_valid) |-> (wiper_pos - $past(wiper_pos)) inside {6'h00, 6'h01, 6'h3F})
    else $error("wiper moved more than one tap");
  AST_NO_WRAP: assert property (
    mode_valid && $past(mode_valid) |-> !({$past(wiper_pos), wiper_pos} inside {12'hFC0, 12'h03F}))
    else $error("wiper wrapped around");
  AST_IDLE_STILL: assert property (
    quiet_q > 12 && (single_mode || dn_q > 12) |-> $stable(wiper_pos))
    else $error("wiper moved with inputs idle");
  AST_NV_WAIT: assert property (
    nv_write.valid |-> still_q >= NV_DELAY_CYC - 4)
    else $error("store before position settled");
  AST_NV_DATA: assert property (
    nv_write.valid |-> nv_write.data == wiper_pos)
    else $error("stored value differs from wiper");
  AST_WORN: assert property (
    nv_worn_out && $past(nv_worn_out) |-> !nv_write.valid)
    else $error("store while memory worn out");
  AST_MODE_HOLD: assert property (
    mode_valid |=> mode_valid && $stable(single_mode))
    else $error("button mode changed");
  AST_MODE_TIME: assert property (
    up_q > 12 |-> mode_valid)
    else $error("button mode not decided in time");
  AST_RESTORE: assert property (
    $rose(mode_valid) && quiet_q > 3 && dn_q > 3 |-> wiper_pos == nv_stored_pos)
    else $error("wiper not restored");

  COV_NV: cover property (nv_write.valid);
  COV_SINGLE: cover property (single_mode && $changed(wiper_pos));
  COV_TOP: cover property (wiper_pos == 6'h3F);
endmodule

bind wiper_ctl wiper_ctl_chk #(.NV_DELAY_CYC(NV_DELAY_CYC)) chk_u
(
  .sys_clk, .rst_b, .up_contact_input_b, .down_contact_input_b, .digital_input_b,
  .nv_stored_pos, .nv_worn_out, .wiper_pos, .nv_write, .single_mode, .mode_valid
);

// ### test/pb_model.sv
`timescale 1ns/10ps
module pb_model
(
  input  wire logic sys_clk,
  output logic      up_b,
  output logic      down_b,
  output logic      dig_b
);
  // Index 0 up, 1 down, 2 digital; released pins sit at pull-up level
  logic [2:0] pins_b = 3'h7;

  assign up_b   = pins_b[0];
  assign down_b = pins_b[1];
  assign dig_b  = pins_b[2];

  // Low span of lo cycles, then high span of hi cycles
  task automatic press(input int pin, input int lo, input int hi);
    @(negedge sys_clk);
    pins_b[pin] = 1'b0;
    repeat (lo) @(negedge sys_clk);
    pins_b[pin] = 1'b1;
    repeat (hi) @(negedge sys_clk);
  endtask

  // Down pin tied high or pulled low by an open-drain driver at power-up
  task automatic strap(input logic v);
    @(negedge sys_clk);
    pins_b[1] = v;
  endtask
endmodule

// ### test/tb.sv
`timescale 1ns/10ps
module tb;
  logic                     sys_clk = 1'b0;
  logic                     rst_b = 1'b0;
  logic                     up_b;
  logic                     down_b;
  logic                     dig_b;
  logic [5:0]               nv_pos = 6'h00;
  logic                     worn = 1'b0;
  logic [5:0]               wiper_pos;
  wiper_ctl_pkg::nv_write_t nv_write;
  logic                     single_mode;
  logic                     mode_valid;
  int                       failures = 0;
  int                       cmp_count = 0;
  int                       nv_cnt = 0;
  // Shortened timing so whole scenarios fit in a few thousand cycles
  localparam int DEB_CYC  = 4;
  localparam int DIG_CYC  = 2;
  localparam int HLD_CYC  = 20;
  localparam int REP_CYC  = 5;
  localparam int IDLE_CYC = 30;
  localparam int NV_CYC   = 40;
  localparam int MODE_CYC = 3;

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (nv_write.valid === 1'b1) nv_cnt++;

  wiper_ctl #(.DEBOUNCE_CYC(DEB_CYC), .DIGITAL_CYC(DIG_CYC), .HOLD_CYC(HLD_CYC),
    .REPEAT_CYC(REP_CYC), .IDLE_REV_CYC(IDLE_CYC), .NV_DELAY_CYC(NV_CYC),
    .MODE_DECIDE_CYC(MODE_CYC)) dut_u
  (.sys_clk, .rst_b, .up_contact_input_b(up_b), .down_contact_input_b(down_b),
   .digital_input_b(dig_b), .nv_stored_pos(nv_pos), .nv_worn_out(worn), .wiper_pos,
   .nv_write, .single_mode, .mode_valid);
  pb_model pb_u (.sys_clk, .up_b, .down_b, .dig_b);

  task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tap(input int pin, input int n);
    repeat (n) pb_u.press(pin, 8, 8);
  endtask

  task automatic power_up(input logic single, input logic [5:0] pos);
    int n;
    n = 0;
    @(negedge sys_clk);
    rst_b = 1'b0;
    nv_pos = pos;
    pb_u.strap(single);
    repeat (8) @(negedge sys_clk);
    rst_b = 1'b1;
    // Strap released before the filter could take it as a down press
    repeat (2) @(negedge sys_clk);
    pb_u.strap(1'b1);
    while (mode_valid !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk);
      n++;
    end
    repeat (12) @(negedge sys_clk);
    chk("mode", {5'h00, single}, {5'h00, single_mode});
    chk("restore", pos, wiper_pos);
  endtask

  task automatic t_dual();
    power_up(1'b0, 6'h0A);
    tap(0, 1);
    chk("up", 6'h0B, wiper_pos);
    tap(1, 1);
    chk("down", 6'h0A, wiper_pos);
    pb_u.press(0, 8, 1);
    pb_u.press(0, 8, 8);
    chk("merged", 6'h0B, wiper_pos);
    pb_u.press(0, 33, 8);
    chk("repeat", 6'h0E, wiper_pos);
    power_up(1'b0, 6'h3E);
    tap(0, 3);
    chk("top", 6'h3F, wiper_pos);
    tap(1, 1);
    chk("back", 6'h3E, wiper_pos);
    $display("test dual done");
  endtask

  task automatic t_single();
    power_up(1'b1, 6'h05);
    tap(0, 2);
    chk("first dir", 6'h07, wiper_pos);
    tap(1, 1);
    chk("down unused", 6'h07, wiper_pos);
    tap(2, 1);
    chk("digital", 6'h08, wiper_pos);
    repeat (40) @(negedge sys_clk);
    tap(0, 1);
    chk("reverse", 6'h07, wiper_pos);
    power_up(1'b1, 6'h3F);
    tap(0, 1);
    chk("end flip", 6'h3E, wiper_pos);
    $display("test single done");
  endtask

  task automatic t_nv();
    int n0;
    power_up(1'b0, 6'h20);
    n0 = nv_cnt;
    tap(0, 1);
    repeat (60) @(negedge sys_clk);
    chk("first store", 6'(n0 + 1), 6'(nv_cnt));
    chk("first data", 6'h21, nv_write.data);
    tap(0, 1);
    repeat (60) @(negedge sys_clk);
    chk("small move", 6'(n0 + 1), 6'(nv_cnt));
    tap(0, 7);
    repeat (60) @(negedge sys_clk);
    chk("big move", 6'(n0 + 2), 6'(nv_cnt));
    chk("big data", 6'h29, nv_write.data);
    worn = 1'b1;
    tap(1, 8);
    repeat (60) @(negedge sys_clk);
    chk("worn", 6'(n0 + 2), 6'(nv_cnt));
    chk("worn run", 6'h21, wiper_pos);
    worn = 1'b0;
    $display("test nv done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    t_dual();
    t_single();
    t_nv();
    finish_test();
  end

  // Tests need about 1000 cycles; allow twenty times that
  initial
  begin
    #80_000;
    failures++;
    finish_test();
  end
endmodule
